/* hw/serial_err_pkg.sv */
// package: register map, field positions and reset values of the receive error flag block
package serial_err_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] RX_DATA_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
    // status register field positions
    localparam int RX_FULL_BIT = 6;
    localparam int OVERRUN_BIT = 5;
    localparam int FRAMING_BIT = 4;
    localparam int PARITY_BIT = 3;
    // control register field positions
    localparam int RX_ENABLE_BIT = 0;
    localparam int SYNC_MODE_BIT = 1;
    localparam int TWO_STOP_BIT = 2;
    // interrupt status and mask field positions
    localparam int IRQ_RX_FULL_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int IRQ_FRAMING_BIT = 2;
    localparam int IRQ_PARITY_BIT = 3;
    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [7:0] RX_DATA_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
endpackage

/* hw/serial_receive_error_flags.sv */
// receive error flag logic of a serial port with an apb register slave
// How it works
// - overrun set when char completes while full
// - overrun cleared by zero write after one read
// - receive disable keeps overrun flag
// - overrun keeps old data, drops new
// - overrun stalls receive; sync mode also transmit
// - framing flag set on bad stop bit
// - framing cleared by zero write after read
// - receive disable keeps framing flag
// - two stop bits: check first only
// - framing error loads data, full not set
// - framing flag stalls receive, sync also transmit
// - parity flag set on parity check failure
// - parity cleared by zero write after read
// - receive disable keeps parity flag
// - parity error loads data, full not set
// - parity flag stalls receive, sync also transmit
// - full flag marks waiting received character
// - writing one to error flags ignored
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module serial_receive_error_flags
    import serial_err_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // receive shifter side: one character completes per pulse
    input wire logic rx_done_i,
    input wire logic [7:0] rx_char_i,
    input wire logic rx_parity_bad_i,
    input wire logic rx_stop1_i,
    input wire logic rx_stop2_i,
    // stall outputs to the shift logic
    output logic rx_stall_o,
    output logic tx_stall_o,
    // interrupt
    output logic irq_o
);

    // software-visible state
    // each flag is a single bit; the status word exists only in the read mux
    logic rx_full_reg;
    logic overrun_reg;
    logic framing_reg;
    logic parity_reg;
    logic [7:0] rx_data_reg;
    logic [2:0] control_reg;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_mask_reg;
    // per-flag "read as one" arming, the precondition for a clearing write
    logic overrun_armed_reg;
    logic framing_armed_reg;
    logic parity_armed_reg;
    logic rx_full_armed_reg;

    // apb decode; a single access phase answers at once
    // the answer is prepared at the setup edge, so pready is already high when the access
    // phase is sampled; this costs a register stage on prdata and saves every wait state
    // only byte lane 0 carries register bits, so a write without that lane does nothing
    // decode is a plain compare on the full byte address; aliases are refused, not folded
    logic access;
    logic wr_en;
    logic rd_en;
    logic hit_status;
    logic hit_control;
    logic hit_data;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic mapped;
    assign access = psel_i & penable_i;
    assign wr_en = access & pwrite_i & pstrb_i[0];
    assign rd_en = access & ~pwrite_i;
    assign hit_status = paddr_i == STATUS_OFFSET;
    assign hit_control = paddr_i == CONTROL_OFFSET;
    assign hit_data = paddr_i == RX_DATA_OFFSET;
    assign hit_irq_status = paddr_i == IRQ_STATUS_OFFSET;
    assign hit_irq_mask = paddr_i == IRQ_MASK_OFFSET;
    assign mapped = hit_status | hit_control | hit_data | hit_irq_status | hit_irq_mask;

    // receive path events
    // the shifter pulses rx_done_i once per character with every qualifier valid in that cycle;
    // each event below lasts exactly that cycle and the character is taken or dropped whole
    // the shifter is expected to stop on the stall outputs; anything it still sends is ignored
    logic any_error;
    logic rx_accept;
    logic frame_bad;
    logic overrun_evt;
    logic framing_evt;
    logic parity_evt;
    logic clean_evt;
    // a set error flag blocks any new character from entering
    assign any_error = overrun_reg | framing_reg | parity_reg;
    assign rx_accept = rx_done_i & control_reg[RX_ENABLE_BIT] & ~any_error;
    assign frame_bad = ~rx_stop1_i;
    assign overrun_evt = rx_accept & rx_full_reg;
    assign framing_evt = rx_accept & ~rx_full_reg & frame_bad;
    assign parity_evt = rx_accept & ~rx_full_reg & rx_parity_bad_i;
    // a clean character is the only one that marks data as waiting
    assign clean_evt = rx_accept & ~rx_full_reg & ~frame_bad & ~rx_parity_bad_i;

    // status write helpers: a zero in a bit position clears only if armed
    logic st_wr; // status write at the access edge
    logic st_rd; // status read at the access edge
    logic overrun_clr; // software clears the overrun flag
    logic framing_clr; // software clears the framing flag
    logic parity_clr; // software clears the parity flag
    logic rx_full_clr; // software releases the waiting character
    assign st_wr = wr_en & hit_status;
    assign st_rd = rd_en & hit_status;
    assign overrun_clr = st_wr & overrun_armed_reg & ~pwdata_i[OVERRUN_BIT];
    assign framing_clr = st_wr & framing_armed_reg & ~pwdata_i[FRAMING_BIT];
    assign parity_clr = st_wr & parity_armed_reg & ~pwdata_i[PARITY_BIT];
    // reading the data word releases the character as well
    assign rx_full_clr = (st_wr & rx_full_armed_reg & ~pwdata_i[RX_FULL_BIT]) | (rd_en & hit_data);

    // holding register: loaded on framing/parity errors too, never on overrun
    // loading a bad character keeps it inspectable, while the untouched full flag tells
    // software that it is not a valid one
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // nothing received yet
            rx_data_reg <= RX_DATA_RESET;
        end else if (rx_accept & ~rx_full_reg) begin
            rx_data_reg <= rx_char_i;
        end
        // overrun and stalled cycles fall through and keep the old character
    end

    // receive-full flag: only clean characters set it
    // a clean character wins over a data read in the same cycle, so it is never lost
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // no character waits after reset
            rx_full_reg <= STATUS_RESET[RX_FULL_BIT];
        end else if (clean_evt) begin
            rx_full_reg <= 1'b1;
        end else if (rx_full_clr) begin
            // cleared by reading the data or by a zero write after reading one
            rx_full_reg <= 1'b0;
        end
        // errors and receive disable leave the flag untouched
    end

    // overrun flag; receive enable does not touch it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // flags come up clear
            overrun_reg <= STATUS_RESET[OVERRUN_BIT];
        end else if (overrun_evt) begin
            overrun_reg <= 1'b1;
        end else if (overrun_clr) begin
            overrun_reg <= 1'b0;
        end
        // no clear on receive disable
        // any other cycle leaves the flag as it was
    end

    // framing flag
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // flags come up clear
            framing_reg <= STATUS_RESET[FRAMING_BIT];
        end else if (framing_evt) begin
            framing_reg <= 1'b1;
        end else if (framing_clr) begin
            framing_reg <= 1'b0;
        end
        // no clear on receive disable
        // any other cycle leaves the flag as it was
    end

    // parity flag
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // flags come up clear
            parity_reg <= STATUS_RESET[PARITY_BIT];
        end else if (parity_evt) begin
            parity_reg <= 1'b1;
        end else if (parity_clr) begin
            parity_reg <= 1'b0;
        end
        // no clear on receive disable
        // any other cycle leaves the flag as it was
    end

    // arming: a status read that sees a flag high arms it; any status write disarms
    // the arm is taken from the word actually returned, captured at the setup edge: a flag
    // that rises between setup and access was not seen by software, and a zero written
    // later must not clear it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overrun_armed_reg <= 1'b0;
            framing_armed_reg <= 1'b0;
            parity_armed_reg <= 1'b0;
            rx_full_armed_reg <= 1'b0;
        end else if (st_rd) begin
            // arm from the returned word, not from the live flags
            overrun_armed_reg <= prdata_o[OVERRUN_BIT];
            framing_armed_reg <= prdata_o[FRAMING_BIT];
            parity_armed_reg <= prdata_o[PARITY_BIT];
            rx_full_armed_reg <= prdata_o[RX_FULL_BIT];
        // a status write, clearing or not, uses up the arm
        end else if (st_wr) begin
            // one read allows one clearing write
            overrun_armed_reg <= 1'b0;
            framing_armed_reg <= 1'b0;
            parity_armed_reg <= 1'b0;
            rx_full_armed_reg <= 1'b0;
        end
    end

    // control register: receive enable, synchronous mode, two stop bits
    // clearing receive enable only blocks new characters; the flags and the held data stay
    // the two-stop setting only matters to the shifter, the second stop bit is never judged
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // receiver off, asynchronous, one stop bit
            control_reg <= CONTROL_RESET;
        end else if (wr_en & hit_control) begin
            control_reg <= pwdata_i[2:0];
        end
        // a write without lane 0 or to another address leaves the settings
    end

    // interrupt status: sticky, write one to clear, a new event wins
    // each event is a single-cycle pulse, so the status bit is what keeps it for software
    logic [3:0] irq_events;
    assign irq_events[IRQ_RX_FULL_BIT] = clean_evt;
    assign irq_events[IRQ_OVERRUN_BIT] = overrun_evt;
    assign irq_events[IRQ_FRAMING_BIT] = framing_evt;
    assign irq_events[IRQ_PARITY_BIT] = parity_evt;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // no pending events
            irq_status_reg <= IRQ_RESET;
        end else if (wr_en & hit_irq_status) begin
            irq_status_reg <= (irq_status_reg & ~pwdata_i[3:0]) | irq_events;
        end else begin
            // no write: events only accumulate
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    // interrupt mask: one enables the matching status bit
    // masking hides a bit from the pin, but the status bit still records the event
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // everything masked
            irq_mask_reg <= IRQ_RESET;
        end else if (wr_en & hit_irq_mask) begin
            irq_mask_reg <= pwdata_i[3:0];
        end
    end

    // interrupt output registered; one cycle behind the status bits
    // the extra cycle keeps the pin free of decode glitches; a handler that reads the status
    // right after the pin rises always finds the bit that caused it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // quiet after reset
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // stall outputs, registered from the flags' next state
    // built from the next state so that the stall changes at the same edge as the flags and
    // the shifter never sees one cycle of a stale stall after a clear or a new error
    logic overrun_next; // overrun flag after this edge
    logic framing_next; // framing flag after this edge
    logic parity_next; // parity flag after this edge
    logic any_error_next; // any error flag after this edge
    assign overrun_next = overrun_evt | (overrun_reg & ~overrun_clr);
    assign framing_next = framing_evt | (framing_reg & ~framing_clr);
    assign parity_next = parity_evt | (parity_reg & ~parity_clr);
    assign any_error_next = overrun_next | framing_next | parity_next;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // no flag set, nothing stalled
            rx_stall_o <= 1'b0;
            tx_stall_o <= 1'b0;
        end else begin
            rx_stall_o <= any_error_next;
            // asynchronous mode lets transmission go on
            tx_stall_o <= any_error_next & control_reg[SYNC_MODE_BIT];
        end
    end

    // read data mux
    // unused bits and unmapped addresses read as zero; an unmapped address is reported
    // through pslverr instead of a special value
    // reading has no side effect here; the data-read release of the full flag sits with the flag
    logic [31:0] read_word;
    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_status) begin
            read_word[RX_FULL_BIT] = rx_full_reg;
            read_word[OVERRUN_BIT] = overrun_reg;
            read_word[FRAMING_BIT] = framing_reg;
            read_word[PARITY_BIT] = parity_reg;
        end else if (hit_control) begin
            read_word[2:0] = control_reg;
        end else if (hit_data) begin
            read_word[7:0] = rx_data_reg;
        end else if (hit_irq_status) begin
            read_word[3:0] = irq_status_reg;
        end else if (hit_irq_mask) begin
            read_word[3:0] = irq_mask_reg;
        end
    end

    // apb answer: ready from the first access cycle, no wait state; error on unmapped address
    // the read word is frozen at the setup edge; the arming logic relies on that word being
    // exactly what software receives
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (psel_i & ~penable_i) begin
            // setup cycle: prepare the answer for the access edge
            pready_o <= 1'b1;
            pslverr_o <= ~mapped;
            prdata_o <= pwrite_i ? 32'h0000_0000 : read_word;
        end else begin
            // access or idle: the answer lasts one cycle
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // the second stop bit is sampled by the shifter but deliberately unused
    // a bad second stop bit is therefore never reported; a receiver that needs that check
    // must do it outside this block
    logic unused_stop2;
    assign unused_stop2 = rx_stop2_i & control_reg[TWO_STOP_BIT];

endmodule
`default_nettype wire

/* tb/remote_station_model.sv */
// model of the remote station as seen after the shifter: one character per call
`timescale 1ns/100ps
`default_nettype none
module remote_station_model (
    // clock
    input wire logic clk_i,
    // completed character
    output logic rx_done_o,
    output logic [7:0] rx_char_o,
    output logic rx_parity_bad_o,
    output logic rx_stop1_o,
    output logic rx_stop2_o
);
    initial begin
        rx_done_o = 1'b0;
        {rx_char_o, rx_parity_bad_o, rx_stop1_o, rx_stop2_o} = 11'h0;
    end
    // fields are valid only with the pulse; afterwards the inverse, so stale values never pass
    task automatic send(input logic [7:0] ch, input logic pbad, input logic s1, input logic s2);
        @(posedge clk_i);
        rx_done_o <= 1'b1;
        {rx_char_o, rx_parity_bad_o, rx_stop1_o, rx_stop2_o} <= {ch, pbad, s1, s2};
        @(posedge clk_i);
        rx_done_o <= 1'b0;
        {rx_char_o, rx_parity_bad_o, rx_stop1_o, rx_stop2_o} <= ~{ch, pbad, s1, s2};
    endtask
endmodule
`default_nettype wire

/* tb/serial_receive_error_flags_properties.sv */
// checker: apb timing and error stall relations at the block ports
`timescale 1ns/100ps
`default_nettype none
module serial_receive_error_flags_chk
    import serial_err_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic rx_done_i,
    input wire logic rx_stall_o,
    input wire logic tx_stall_o
);
    // a status write completing in this cycle
    logic st_wr;
    assign st_wr = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0] && (paddr_i == STATUS_OFFSET);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_ready_no_wait: assert property (psel_i && penable_i |-> pready_o)
        else $error("pready missing in access cycle");
    chk_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    chk_unmapped_error: assert property (psel_i && penable_i && !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})
        |-> pslverr_o)
        else $error("unmapped access without error");
    chk_tx_needs_rx: assert property (tx_stall_o |-> rx_stall_o)
        else $error("transmit stall without error flag");
    chk_stall_rise_cause: assert property ($rose(rx_stall_o) |-> $past(rx_done_i))
        else $error("stall rose without a character");
    chk_stall_fall_cause: assert property ($fell(rx_stall_o) |-> $past(st_wr) || $past(st_wr, 2))
        else $error("stall fell without a status write");
    chk_stall_holds: assert property (rx_stall_o && !st_wr && !$past(st_wr) |=> rx_stall_o)
        else $error("error flag lost without a clearing write");
    chk_ones_ignored: assert property (st_wr && pwdata_i[5:3] == 3'b111 && rx_stall_o |=> rx_stall_o)
        else $error("writing ones cleared an error flag");
endmodule
bind serial_receive_error_flags serial_receive_error_flags_chk u_chk (.clk_i, .sys_rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .rx_done_i, .rx_stall_o, .tx_stall_o);
`default_nettype wire

/* tb/serial_receive_error_flags_tb_top.sv */
// testbench: receive error flags reached over apb, characters from the station model
`timescale 1ns/100ps
`default_nettype none
module serial_receive_error_flags_tb_top;
    import serial_err_pkg::*;
    // clock, reset and apb master
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rx_done, rx_pbad, rx_s1, rx_s2, rx_stall, tx_stall, irq;
    logic [7:0] rx_char;
    int fail_count = 0;
    int n_tests = 0;
    always #2 clk = ~clk;
    serial_receive_error_flags u_serial_receive_error_flags (.clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_done_i(rx_done), .rx_char_i(rx_char),
        .rx_parity_bad_i(rx_pbad), .rx_stop1_i(rx_s1), .rx_stop2_i(rx_s2), .rx_stall_o(rx_stall),
        .tx_stall_o(tx_stall), .irq_o(irq));
    remote_station_model u_remote (.clk_i(clk), .rx_done_o(rx_done), .rx_char_o(rx_char),
        .rx_parity_bad_o(rx_pbad), .rx_stop1_o(rx_s1), .rx_stop2_o(rx_s2));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; data and error taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask
    task automatic t_reset();
        rd_chk("status reset", STATUS_OFFSET, {24'h0, STATUS_RESET});
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask
    task automatic t_overrun();
        apb(1'b1, CONTROL_OFFSET, 32'h1);
        u_remote.send(8'h3c, 1'b0, 1'b1, 1'b1);
        rd_chk("full set", STATUS_OFFSET, 32'h40);
        u_remote.send(8'hc3, 1'b0, 1'b1, 1'b1);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        rd_chk("late overrun kept", STATUS_OFFSET, 32'h20);
        check("rx stall", 32'h1, {31'h0, rx_stall});
        check("async tx free", 32'h0, {31'h0, tx_stall});
        u_remote.send(8'h99, 1'b0, 1'b1, 1'b1);
        rd_chk("old data kept", RX_DATA_OFFSET, 32'h3c);
        apb(1'b1, STATUS_OFFSET, 32'hff);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        apb(1'b1, CONTROL_OFFSET, 32'h0);
        rd_chk("ones and unarmed zero", STATUS_OFFSET, 32'h20);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        rd_chk("overrun cleared", STATUS_OFFSET, 32'h0);
        $display("test overrun done");
    endtask
    task automatic t_framing();
        apb(1'b1, CONTROL_OFFSET, 32'h7);
        u_remote.send(8'h5a, 1'b0, 1'b1, 1'b0);
        rd_chk("second stop ignored", STATUS_OFFSET, 32'h40);
        rd_chk("clean data", RX_DATA_OFFSET, 32'h5a);
        u_remote.send(8'h81, 1'b0, 1'b0, 1'b1);
        rd_chk("framing flag", STATUS_OFFSET, 32'h10);
        check("sync tx stall", 32'h1, {31'h0, tx_stall});
        rd_chk("framing data", RX_DATA_OFFSET, 32'h81);
        apb(1'b1, CONTROL_OFFSET, 32'h2);
        rd_chk("framing kept", STATUS_OFFSET, 32'h10);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        rd_chk("framing cleared", STATUS_OFFSET, 32'h0);
        $display("test framing done");
    endtask
    task automatic t_parity();
        apb(1'b1, CONTROL_OFFSET, 32'h1);
        apb(1'b1, IRQ_STATUS_OFFSET, 32'hf);
        apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
        u_remote.send(8'h44, 1'b1, 1'b1, 1'b1);
        rd_chk("parity flag", STATUS_OFFSET, 32'h08);
        check("async stall", 32'h1, {30'h0, tx_stall, rx_stall});
        check("irq masked", 32'h0, {31'h0, irq});
        rd_chk("parity data", RX_DATA_OFFSET, 32'h44);
        apb(1'b1, IRQ_MASK_OFFSET, 32'h8);
        rd_chk("irq status", IRQ_STATUS_OFFSET, 32'h8);
        check("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, IRQ_STATUS_OFFSET, 32'h8);
        rd_chk("irq cleared", IRQ_STATUS_OFFSET, 32'h0);
        check("irq low", 32'h0, {31'h0, irq});
        apb(1'b1, CONTROL_OFFSET, 32'h0);
        rd_chk("parity kept", STATUS_OFFSET, 32'h08);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        rd_chk("parity cleared", STATUS_OFFSET, 32'h0);
        $display("test parity done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_overrun();
        t_framing();
        t_parity();
        test_done();
    end
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #80000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
